//--- riw_pkg.sv
// Package with constants, register map and types for the remote I/O watchdog core
// ****************************************************************
// Overview of operation
// - Setup mode runs the link at fixed 115.2 kbaud, ignoring stored rate.
// - Operate mode runs the link at the stored rate, default 2.5 Mbaud.
// - Jumper up selects operate mode, jumper down selects setup mode.
// - No host traffic within watchdog period sets fault and disables outputs.
// - Default watchdog period is 50 ms; host must access faster than 20 Hz.
// - While fault is set, output writes are ignored until host clears fault.
// - Fault is set at startup; host clears it before normal output operation.
// - Watchdog period counts milliseconds; zero disables the watchdog.
// - Stored parameters are copied to working copies at power-up only.
// - Stored rate index 0..11 decodes 9600 up to 10M baud.
// - Output word holds 8 or 24 bits, right-justified, bit 0 first output.
// - Each transfer returns 48 input process bits plus 8 fault bits.
// - Working watchdog period is settable at run time; stored one only seeds.
// - With separate logic supply, loss of field voltage is reported.
// ****************************************************************
package riw_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned TICK_US         = 1000;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned SETUP_BAUD      = 115_200;
    // Parameter defaults
    localparam logic [15:0] WD_MS_RST       = 16'h0032;
    localparam logic [3:0]  RATE_IDX_RST    = 4'h9;
    localparam logic [3:0]  RATE_IDX_MAX    = 4'hb;
    // Register byte offsets
    localparam logic [7:0]  A_CTRL          = 8'h00;
    localparam logic [7:0]  A_OUTPUT        = 8'h04;
    localparam logic [7:0]  A_WD_WORK       = 8'h08;
    localparam logic [7:0]  A_WD_STORED     = 8'h0c;
    localparam logic [7:0]  A_RATE_STORED   = 8'h10;
    localparam logic [7:0]  A_ID_STORED     = 8'h14;
    localparam logic [7:0]  A_ID_WORK       = 8'h18;
    localparam logic [7:0]  A_STATUS        = 8'h1c;
    localparam logic [7:0]  A_INPUT_LO      = 8'h20;
    localparam logic [7:0]  A_INPUT_HI      = 8'h24;
    localparam logic [7:0]  A_IRQ_STAT      = 8'h28;
    localparam logic [7:0]  A_IRQ_EN        = 8'h2c;
    localparam logic [7:0]  A_IRQ_CLR       = 8'h30;
    localparam logic [7:0]  A_BAUD          = 8'h34;
    // Control register fields
    localparam int unsigned CTRL_FAULT_CLR  = 0;
    localparam int unsigned CTRL_KICK       = 1;
    // Status register fields
    localparam int unsigned ST_FAULT        = 0;
    localparam int unsigned ST_SETUP        = 1;
    localparam int unsigned ST_FIELD_LOSS   = 2;
    localparam int unsigned ST_WD_BITE      = 3;
    // Interrupt bits
    localparam int unsigned IRQ_BITE        = 0;
    localparam int unsigned IRQ_FIELD       = 1;
    localparam int unsigned IRQ_W           = 2;
    // Fault byte fields
    localparam int unsigned FB_WD           = 0;
    localparam int unsigned FB_FIELD        = 1;
    localparam int unsigned FB_STARTUP      = 2;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

    typedef enum logic [1:0] {RIW_BOOT, RIW_LOAD, RIW_RUN} riw_phase_e;
endpackage

//--- riw_rate_decode.sv
// Link baud-rate selector from jumper and stored rate index
`timescale 1ns/100ps
module riw_rate_decode (
    input  wire logic        setup_mode,
    input  wire logic [3:0]  rate_idx,
    output logic      [23:0] baud
);
    // ****************************************************************
    // Rate table
    // ****************************************************************
    function automatic logic [23:0] idx_to_baud(input logic [3:0] idx);
        case (idx)
            4'h0:    idx_to_baud = 24'd9600;
            4'h1:    idx_to_baud = 24'd19200;
            4'h2:    idx_to_baud = 24'd38400;
            4'h3:    idx_to_baud = 24'd57600;
            4'h4:    idx_to_baud = 24'd115200;
            4'h5:    idx_to_baud = 24'd230400;
            4'h6:    idx_to_baud = 24'd460800;
            4'h7:    idx_to_baud = 24'd921600;
            4'h8:    idx_to_baud = 24'd1250000;
            4'h9:    idx_to_baud = 24'd2500000;
            4'ha:    idx_to_baud = 24'd5000000;
            4'hb:    idx_to_baud = 24'd10000000;
            default: idx_to_baud = 24'd2500000;
        endcase
    endfunction

    // Setup mode overrides stored index
    always_comb begin
        if (setup_mode) begin
            baud = 24'(riw_pkg::SETUP_BAUD);
        end else begin
            baud = idx_to_baud(rate_idx);
        end
    end
endmodule

//--- riw_ms_tick.sv
// Millisecond tick generator
`timescale 1ns/100ps
module riw_ms_tick #(
    parameter int unsigned CYCLES = riw_pkg::TICK_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic restart,
    output logic      tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } riw_tick_s;
    riw_tick_s st_q;
    riw_tick_s st_d;

    // Free count, restarted with the watchdog
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (restart) begin
            st_d.cnt = 32'h0;
        end else if (st_q.cnt == 32'(CYCLES - 1)) begin
            st_d.cnt = 32'h0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;
endmodule

//--- riw_core.sv
// Remote I/O card control core: watchdog, fault, parameters, AXI4-Lite registers
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module riw_core #(
    parameter int unsigned OUT_W       = 24,
    parameter int unsigned TICK_CYCLES = riw_pkg::TICK_CYCLES
) (
    input  wire logic              clk_sys,
    input  wire logic              srst,
    // AXI4-Lite slave
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Pins
    input  wire logic              mode_select_jumper,
    input  wire logic              field_supply_ok,
    input  wire logic              logic_supply_separate,
    input  wire logic [47:0]       field_inputs,
    // Non-volatile store contents, valid at power-up
    input  wire logic [15:0]       stored_watchdog_period,
    input  wire logic [3:0]        stored_link_rate_index,
    input  wire logic [31:0]       stored_card_id_number,
    // Host link traffic marker
    input  wire logic              host_access,
    output logic [OUT_W-1:0]       field_outputs,
    output logic                   fault_flag,
    output logic                   setup_mode,
    output logic [23:0]            link_baud,
    output logic [55:0]            transfer_data,
    output logic                   irq
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        riw_pkg::riw_phase_e     phase;
        logic [2:0]              jmp_s;
        logic [1:0]              fld_s;
        logic [1:0]              sep_s;
        logic [47:0]             in_s1;
        logic [47:0]             in_s2;
        logic [1:0]              acc_s;
        logic                    acc_d;
        logic [15:0]             wd_work;
        logic [15:0]             wd_stored;
        logic [3:0]              rate_stored;
        logic [3:0]              rate_work;    // Live link rate index, seeded at power-up
        logic [31:0]             id_stored;
        logic [31:0]             id_work;
        logic [15:0]             ms_cnt;
        logic                    fault;
        logic                    startup;
        logic                    bite;
        logic [OUT_W-1:0]        out_req;
        logic [OUT_W-1:0]        out_pin;
        logic [riw_pkg::IRQ_W-1:0] ist;
        logic [riw_pkg::IRQ_W-1:0] ien;
        logic                    irq;
        logic                    aw_h;
        logic [7:0]              aw_a;
        logic                    w_h;
        logic [31:0]             w_d;
        logic [3:0]              w_s;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
        logic                    setup;
        logic [23:0]             baud;
        logic [55:0]             xfer;
    } riw_core_s;
    riw_core_s st_q;
    riw_core_s st_d;

    logic        tick;
    logic        restart;
    logic [23:0] baud_w;
    logic        field_loss;

    // Field loss only meaningful with a separate logic supply
    assign field_loss = st_q.sep_s[1] & ~st_q.fld_s[1];

    riw_ms_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_sys (clk_sys),
        .srst    (srst),
        .restart (restart),
        .tick    (tick)
    );

    riw_rate_decode u_rate (
        .setup_mode (~st_q.jmp_s[2]),
        .rate_idx   (st_q.rate_work),
        .baud       (baud_w)
    );

    // Register read mux
    function automatic logic [31:0] rd_mux(input riw_core_s s, input logic [7:0] a,
                                           input logic fl);
        if (a == riw_pkg::A_CTRL)
            rd_mux = 32'h0;
        else if (a == riw_pkg::A_OUTPUT)
            rd_mux = 32'(s.out_pin);
        else if (a == riw_pkg::A_WD_WORK)
            rd_mux = {16'h0, s.wd_work};
        else if (a == riw_pkg::A_WD_STORED)
            rd_mux = {16'h0, s.wd_stored};
        else if (a == riw_pkg::A_RATE_STORED)
            rd_mux = {28'h0, s.rate_stored};
        else if (a == riw_pkg::A_ID_STORED)
            rd_mux = s.id_stored;
        else if (a == riw_pkg::A_ID_WORK)
            rd_mux = s.id_work;
        else if (a == riw_pkg::A_STATUS)
            rd_mux = {28'h0, s.bite, fl, s.setup, s.fault};
        else if (a == riw_pkg::A_INPUT_LO)
            rd_mux = s.in_s2[31:0];
        else if (a == riw_pkg::A_INPUT_HI)
            rd_mux = {16'h0, s.in_s2[47:32]};
        else if (a == riw_pkg::A_IRQ_STAT)
            rd_mux = 32'(s.ist);
        else if (a == riw_pkg::A_IRQ_EN)
            rd_mux = 32'(s.ien);
        else if (a == riw_pkg::A_BAUD)
            rd_mux = {8'h0, s.baud};
        else
            rd_mux = 32'h0;
    endfunction

    // Known address check
    function automatic logic known(input logic [7:0] a);
        known = (a[1:0] == 2'b00) && (a <= riw_pkg::A_BAUD);
    endfunction

    logic        do_wr;
    logic        do_rd;
    logic [31:0] wmask;
    logic        clr_req;
    logic        kick_wr;
    logic        expire;
    logic [riw_pkg::IRQ_W-1:0] ev;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        // Pin synchronisers
        st_d.jmp_s = {st_q.jmp_s[1:0], mode_select_jumper};
        st_d.fld_s = {st_q.fld_s[0], field_supply_ok};
        st_d.sep_s = {st_q.sep_s[0], logic_supply_separate};
        st_d.in_s1 = field_inputs;
        st_d.in_s2 = st_q.in_s1;
        st_d.acc_s = {st_q.acc_s[0], host_access};
        st_d.acc_d = st_q.acc_s[1];
        // Write channel capture
        if (s_axi_awvalid && !st_q.aw_h) begin
            st_d.aw_h = 1'b1;
            st_d.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_h) begin
            st_d.w_h = 1'b1;
            st_d.w_d = s_axi_wdata;
            st_d.w_s = s_axi_wstrb;
        end
        do_wr = st_q.aw_h && st_q.w_h && !st_q.bvalid;
        wmask = {{8{st_q.w_s[3]}}, {8{st_q.w_s[2]}}, {8{st_q.w_s[1]}}, {8{st_q.w_s[0]}}};
        clr_req = 1'b0;
        kick_wr = 1'b0;
        if (do_wr) begin
            st_d.aw_h = 1'b0;
            st_d.w_h = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = known(st_q.aw_a) ? riw_pkg::RESP_OKAY : riw_pkg::RESP_SLVERR;
            if (st_q.aw_a == riw_pkg::A_CTRL && st_q.w_s[0]) begin
                clr_req = st_q.w_d[riw_pkg::CTRL_FAULT_CLR];
                kick_wr = st_q.w_d[riw_pkg::CTRL_KICK];
            end else if (st_q.aw_a == riw_pkg::A_OUTPUT) begin
                st_d.out_req = OUT_W'((st_q.w_d & wmask) | (32'(st_q.out_req) & ~wmask));
            end else if (st_q.aw_a == riw_pkg::A_WD_WORK) begin
                // Working period changes the live timer at once
                st_d.wd_work = 16'((st_q.w_d & wmask) | ({16'h0, st_q.wd_work} & ~wmask));
            end else if (st_q.aw_a == riw_pkg::A_WD_STORED) begin
                // Stored values only reach working copies at next power-up
                st_d.wd_stored = 16'((st_q.w_d & wmask) | ({16'h0, st_q.wd_stored} & ~wmask));
            end else if (st_q.aw_a == riw_pkg::A_RATE_STORED && st_q.w_s[0]) begin
                if (st_q.w_d[3:0] <= riw_pkg::RATE_IDX_MAX) begin
                    st_d.rate_stored = st_q.w_d[3:0];
                end
            end else if (st_q.aw_a == riw_pkg::A_ID_STORED) begin
                st_d.id_stored = (st_q.w_d & wmask) | (st_q.id_stored & ~wmask);
            end else if (st_q.aw_a == riw_pkg::A_ID_WORK) begin
                st_d.id_work = (st_q.w_d & wmask) | (st_q.id_work & ~wmask);
            end else if (st_q.aw_a == riw_pkg::A_IRQ_EN && st_q.w_s[0]) begin
                st_d.ien = st_q.w_d[riw_pkg::IRQ_W-1:0];
            end
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        // Read channel
        do_rd = s_axi_arvalid && !st_q.rvalid;
        if (do_rd) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = rd_mux(st_q, s_axi_araddr, field_loss);
            st_d.rresp = known(s_axi_araddr) ? riw_pkg::RESP_OKAY : riw_pkg::RESP_SLVERR;
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        // Power-up parameter copy
        case (st_q.phase)
            riw_pkg::RIW_BOOT: begin
                st_d.phase = riw_pkg::RIW_LOAD;
            end
            riw_pkg::RIW_LOAD: begin
                st_d.wd_stored = stored_watchdog_period;
                st_d.rate_stored = (stored_link_rate_index <= riw_pkg::RATE_IDX_MAX)
                                   ? stored_link_rate_index : riw_pkg::RATE_IDX_RST;
                st_d.rate_work = st_d.rate_stored;
                st_d.id_stored = stored_card_id_number;
                st_d.wd_work = stored_watchdog_period;
                st_d.id_work = stored_card_id_number;
                st_d.phase = riw_pkg::RIW_RUN;
            end
            default: begin
                st_d.phase = riw_pkg::RIW_RUN;
            end
        endcase
        // Watchdog: count ms since last host access
        expire = 1'b0;
        if (restart) begin
            st_d.ms_cnt = 16'h0;
        end else if (tick && st_q.wd_work != 16'h0) begin
            if (st_q.ms_cnt + 16'h1 >= st_q.wd_work) begin
                expire = 1'b1;
                st_d.ms_cnt = 16'h0;
            end else begin
                st_d.ms_cnt = st_q.ms_cnt + 16'h1;
            end
        end
        // Fault flag: set wins over clear
        if (expire || field_loss) begin
            st_d.fault = 1'b1;
            st_d.bite = st_q.bite | expire;
        end else if (clr_req) begin
            st_d.fault = 1'b0;
            st_d.startup = 1'b0;
            st_d.bite = 1'b0;
        end
        // Outputs only follow requests while fault is clear
        if (st_d.fault) begin
            st_d.out_pin = '0;
        end else if (!st_q.fault) begin
            st_d.out_pin = st_d.out_req;
        end
        if (st_q.fault) begin
            st_d.out_req = st_q.out_req & st_q.out_pin;
        end
        // Interrupt status: set wins over clear
        ev = '0;
        ev[riw_pkg::IRQ_BITE] = expire;
        ev[riw_pkg::IRQ_FIELD] = field_loss;
        if (do_wr && st_q.aw_a == riw_pkg::A_IRQ_CLR && st_q.w_s[0]) begin
            st_d.ist = st_q.ist & ~st_q.w_d[riw_pkg::IRQ_W-1:0];
        end
        st_d.ist = st_d.ist | ev;
        st_d.irq = |(st_d.ist & st_d.ien);
        // Link rate and transfer frame
        st_d.setup = ~st_q.jmp_s[2];
        st_d.baud = baud_w;
        st_d.xfer = {5'h0, st_q.startup, field_loss, st_q.bite, st_q.in_s2};
    end

    // Restart timer on host link traffic or kick write
    assign restart = (st_q.acc_s[1] & ~st_q.acc_d) | kick_wr;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q <= '0;
            st_q.phase <= riw_pkg::RIW_BOOT;
            st_q.fault <= 1'b1;
            st_q.startup <= 1'b1;
            st_q.wd_work <= riw_pkg::WD_MS_RST;
            st_q.wd_stored <= riw_pkg::WD_MS_RST;
            st_q.rate_stored <= riw_pkg::RATE_IDX_RST;
            st_q.rate_work <= riw_pkg::RATE_IDX_RST;
            st_q.setup <= 1'b1;
            st_q.baud <= 24'(riw_pkg::SETUP_BAUD);
            st_q.bresp <= riw_pkg::RESP_OKAY;
            st_q.rresp <= riw_pkg::RESP_OKAY;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready = ~st_q.aw_h;
    assign s_axi_wready  = ~st_q.w_h;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = ~st_q.rvalid;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rdata   = st_q.rdata;
    assign s_axi_rresp   = st_q.rresp;
    assign field_outputs = st_q.out_pin;
    assign fault_flag    = st_q.fault;
    assign setup_mode    = st_q.setup;
    assign link_baud     = st_q.baud;
    assign transfer_data = st_q.xfer;
    assign irq           = st_q.irq;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_FAULT_BLOCKS: assert property (@(posedge clk_sys) disable iff (srst)
        fault_flag |-> field_outputs == '0) else $error("Outputs live under fault");
    AST_SETUP_RATE: assert property (@(posedge clk_sys) disable iff (srst)
        setup_mode |-> link_baud == 24'd115200) else $error("Setup rate wrong");
    AST_OPER_RATE: assert property (@(posedge clk_sys) disable iff (srst)
        (!setup_mode && st_q.rate_work == 4'h9) |-> link_baud == 24'd2500000)
        else $error("Operate rate wrong");
    AST_JUMPER: assert property (@(posedge clk_sys) disable iff (srst)
        $past(st_q.jmp_s[2]) |-> !setup_mode) else $error("Jumper up not operate");
    AST_WD_OFF: assert property (@(posedge clk_sys) disable iff (srst)
        (st_q.wd_work == 16'h0 && !st_q.bite) |=> !st_q.bite)
        else $error("Disabled watchdog bit");
    AST_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
        (fault_flag && $past(fault_flag)) |-> $stable(field_outputs))
        else $error("Outputs moved under fault");
    AST_RESTART: assert property (@(posedge clk_sys) disable iff (srst)
        restart |=> st_q.ms_cnt == 16'h0) else $error("Timer not restarted");
    AST_BITE: assert property (@(posedge clk_sys) disable iff (srst)
        expire |=> fault_flag && st_q.bite) else $error("Bite did not fault");
    AST_LOAD: assert property (@(posedge clk_sys) disable iff (srst)
        st_q.phase == riw_pkg::RIW_LOAD |=> st_q.wd_work == $past(stored_watchdog_period))
        else $error("Working period not seeded");
    AST_XFER: assert property (@(posedge clk_sys) disable iff (srst)
        transfer_data[47:0] == $past(st_q.in_s2)) else $error("Transfer inputs wrong");
endmodule

//--- riw_host_model.sv
// Host link model that marks periodic host accesses
`timescale 1ns/100ps
module riw_host_model #(
    parameter int unsigned PERIOD = 20
) (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic enable,
    output logic      host_access
);
    logic [7:0] cnt_q;
    // One pulse per period, well inside the watchdog span
    always @(posedge clk_sys) begin
        if (srst || !enable) begin
            cnt_q       <= 8'h00;
            host_access <= 1'b0;
        end else begin
            cnt_q       <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
            host_access <= (cnt_q == 8'h00);
        end
    end
endmodule

//--- tb_remote_io_watchdog_fault_params.sv
// Self-checking bench for the remote I/O watchdog core
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module tb_remote_io_watchdog_fault_params;
    logic clk_sys = 0, srst = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rd;
    logic [1:0] rr;
    logic jmp = 0, host_en = 0, host_access, fok = 1, sep = 1;
    logic [3:0] idx = 4'hb, ws = 4'hf;
    logic [47:0] fin = 48'h0123_4567_89ab;
    logic awr, wr, bv, arr, rv, fault_flag, setup_mode, irq;
    logic [1:0] br, rrs;
    logic [31:0] rdata;
    logic [23:0] field_outputs, link_baud;
    logic [55:0] transfer_data;
    int failures = 0, num_checks = 0;
    // Jumper, rate index, expected baud
    logic [28:0] rows [13] = '{29'h1_0_002580, 29'h1_1_004b00,
        29'h1_2_009600, 29'h1_3_00e100, 29'h1_4_01c200, 29'h1_5_038400,
        29'h1_6_070800, 29'h1_7_0e1000, 29'h1_8_1312d0, 29'h1_9_2625a0,
        29'h1_a_4c4b40, 29'h1_b_989680, 29'h0_b_01c200};
    riw_core #(.OUT_W(24), .TICK_CYCLES(10)) u_dut (.clk_sys(clk_sys), .srst(srst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
        .mode_select_jumper(jmp), .field_supply_ok(fok), .logic_supply_separate(sep),
        .field_inputs(fin), .stored_watchdog_period(16'h0005),
        .stored_link_rate_index(idx), .stored_card_id_number(32'h0000_00a5),
        .host_access(host_access), .field_outputs(field_outputs),
        .fault_flag(fault_flag), .setup_mode(setup_mode), .link_baud(link_baud),
        .transfer_data(transfer_data), .irq(irq));
    riw_host_model #(.PERIOD(20)) u_host (.clk_sys(clk_sys), .srst(srst),
        .enable(host_en), .host_access(host_access));
    // Clock at 100 MHz
    initial forever #5 clk_sys = ~clk_sys;
    task stop_test;
        if (failures == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task do_reset;
        srst <= 1'b1;
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
    // Write: address and data offered together, each dropped when taken
    task axw(input logic [7:0] a, input logic [31:0] d);
        bit done;
        done = 0;
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
            if (bv === 1'b1) done = 1;
        end
        brdy <= 1'b0;
        @(posedge clk_sys);
    endtask
    task axr(input logic [7:0] a);
        bit done;
        done = 0;
        ara <= a; arv <= 1'b1; rrdy <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            if (arr === 1'b1) arv <= 1'b0;
            if (rv === 1'b1) begin done = 1; rd = rdata; rr = rrs; end
        end
        rrdy <= 1'b0;
        @(posedge clk_sys);
    endtask
    initial begin
        #200000;
        failures++;
        stop_test();
    end
    initial begin
        // Rate decode per jumper and stored index
        foreach (rows[i]) begin
            jmp <= rows[i][28]; idx <= rows[i][27:24];
            do_reset();
            `CHK(link_baud, rows[i][23:0])
            `CHK(setup_mode, ~rows[i][28])
            `CHK(fault_flag, 1'b1)
        end
        axr(riw_pkg::A_WD_WORK);
        `CHK(rd, 32'h0000_0005)
        `CHK(transfer_data[47:0], fin)
        host_en <= 1'b1;
        axw(riw_pkg::A_OUTPUT, 32'h00aa_aaaa);
        `CHK(field_outputs, 24'h000000)
        axw(riw_pkg::A_CTRL, 32'h1);
        axw(riw_pkg::A_OUTPUT, 32'h00aa_aaaa);
        axw(riw_pkg::A_IRQ_EN, 32'h1);
        repeat (150) @(posedge clk_sys);
        `CHK(fault_flag, 1'b0)
        `CHK(field_outputs, 24'haaaaaa)
        // Traffic stops: watchdog must bite within its span
        host_en <= 1'b0;
        repeat (100) @(posedge clk_sys);
        `CHK(fault_flag, 1'b1)
        `CHK(field_outputs, 24'h000000)
        `CHK(irq, 1'b1)
        axr(riw_pkg::A_IRQ_STAT);
        `CHK(rd[0], 1'b1)
        host_en <= 1'b1;
        // Let host traffic restart the timer so no bite lands on the clear
        repeat (10) @(posedge clk_sys);
        axw(riw_pkg::A_IRQ_CLR, 32'h1);
        `CHK(irq, 1'b0)
        // Zero working period disables the watchdog
        axw(riw_pkg::A_CTRL, 32'h1);
        axw(riw_pkg::A_WD_WORK, 32'h0);
        host_en <= 1'b0;
        repeat (200) @(posedge clk_sys);
        `CHK(fault_flag, 1'b0)
        axr(8'h3c);
        `CHK(rr, riw_pkg::RESP_SLVERR)
        // Field supply lost with separate logic supply: fault and report
        fok <= 1'b0;
        repeat (5) @(posedge clk_sys);
        `CHK(fault_flag, 1'b1)
        `CHK(transfer_data[49], 1'b1)
        axr(riw_pkg::A_STATUS);
        `CHK(rd[3:0], 4'h7)
        // Shared supply: no field loss, fault can be cleared
        sep <= 1'b0;
        repeat (5) @(posedge clk_sys);
        axw(riw_pkg::A_CTRL, 32'h1);
        `CHK(fault_flag, 1'b0)
        // Byte strobe: only the low output byte is written
        ws <= 4'h1;
        axw(riw_pkg::A_OUTPUT, 32'hffff_ff55);
        `CHK(field_outputs, 24'h000055)
        ws <= 4'hf;
        fok <= 1'b1;
        stop_test();
    end
endmodule
